// ==== verilog/srru_top.sv ====
// Purpose: decode and check of privileged and state register reads
// Assumes: instruction and register values arrive on the core clock
// Notes: one instruction taken per valid cycle unless stalled
`timescale 1ns/1ps
module srru_top (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Instruction in
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic [63:0] pc,
    input wire logic priv_mode,
    output logic instr_ready,
    // Floating-point drain pin, asynchronous
    input wire logic fp_busy,
    // Trap entry write
    input wire logic trap_wr,
    input wire logic [srru_pkg::TL_W-1:0] trap_wr_level,
    input wire logic [63:0] trap_wr_pc,
    input wire logic [63:0] trap_wr_npc,
    input wire logic [63:0] trap_wr_state,
    input wire logic [63:0] trap_wr_type,
    // Current register values
    input wire logic [srru_pkg::TL_W-1:0] trap_level,
    input wire logic [63:0] cycle_tick,
    input wire logic [63:0] trap_base,
    input wire logic [63:0] proc_state,
    input wire logic [63:0] irq_level,
    input wire logic [63:0] window_ptr,
    input wire logic [63:0] window_ctl [5],
    input wire logic [63:0] fp_queue,
    input wire logic [63:0] version_reg,
    input wire logic [63:0] mult_reg,
    input wire logic [63:0] cond_codes,
    input wire logic [63:0] aspace_reg,
    input wire logic [63:0] fp_status,
    input wire logic [63:0] perf_control,
    input wire logic [63:0] perf_counters,
    input wire logic [63:0] dispatch_control,
    input wire logic [63:0] graphics_status,
    input wire logic [63:0] soft_interrupt,
    input wire logic [63:0] tick_compare,
    input wire logic [63:0] system_tick,
    input wire logic [63:0] system_tick_compare,
    // Result
    output logic done,
    output logic [63:0] rd_data,
    output logic [4:0] rd_addr,
    output logic rd_we,
    output logic bad_opcode_fault,
    output logic priv_op_fault,
    output logic priv_action_fault,
    output logic fpu_off_fault,
    output logic store_barrier,
    output logic memory_barrier
);
    logic fp_busy_s;
    logic [63:0] tb_pc;
    logic [63:0] tb_npc;
    logic [63:0] tb_state;
    logic [63:0] tb_type;
    logic [1:0] f_op;
    logic [4:0] f_rd;
    logic [5:0] f_op3;
    logic [4:0] f_rs1;
    logic f_i;
    logic is_priv;
    logic is_state;
    logic wait_fp;
    srru_pkg::srru_result_t res;
    logic [63:0] data;

    // ========================================
    // Synchronised drain status and trap copies
    srru_sync3 u_sync (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .d(fp_busy),
        .q(fp_busy_s)
    );

    srru_trap_bank u_bank (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wr_en(trap_wr),
        .wr_level(trap_wr_level),
        .wr_pc(trap_wr_pc),
        .wr_npc(trap_wr_npc),
        .wr_state(trap_wr_state),
        .wr_type(trap_wr_type),
        .rd_level(trap_level),
        .rd_pc(tb_pc),
        .rd_npc(tb_npc),
        .rd_state(tb_state),
        .rd_type(tb_type)
    );

    // ========================================
    // Field extraction
    assign f_op = instr[srru_pkg::OP_HI:srru_pkg::OP_LO];
    assign f_rd = instr[srru_pkg::RD_HI:srru_pkg::RD_LO];
    assign f_op3 = instr[srru_pkg::OP3_HI:srru_pkg::OP3_LO];
    assign f_rs1 = instr[srru_pkg::RS1_HI:srru_pkg::RS1_LO];
    assign f_i = instr[srru_pkg::I_BIT];
    assign is_priv = (f_op == srru_pkg::OP_ARITH) && (f_op3 == srru_pkg::OP3_RD_PRIV);
    assign is_state = (f_op == srru_pkg::OP_ARITH) && (f_op3 == srru_pkg::OP3_RD_STATE);
    // Fp status read holds while drain is pending
    assign wait_fp = is_state && (f_rs1 == srru_pkg::SR_FP_STATUS) && fp_busy_s;

    // ========================================
    // Privileged read decode
    function automatic srru_pkg::srru_result_t priv_chk(input logic [4:0] s);
        srru_pkg::srru_result_t r;
        r = srru_pkg::SRRU_OK;
        if (!priv_mode) begin
            r = srru_pkg::SRRU_PRIV_OP;
        end else if (s >= srru_pkg::PR_RSV_FIRST && s <= srru_pkg::PR_RSV_LAST) begin
            r = srru_pkg::SRRU_BAD_OPCODE;
        end else if (s <= srru_pkg::PR_TRAP_TYPE && trap_level == '0) begin
            r = srru_pkg::SRRU_BAD_OPCODE;
        end
        return r;
    endfunction

    // ========================================
    // State read decode and access checks
    function automatic srru_pkg::srru_result_t state_chk(input logic [4:0] s);
        srru_pkg::srru_result_t r;
        r = srru_pkg::SRRU_OK;
        case (s)
            srru_pkg::SR_MULT, srru_pkg::SR_COND, srru_pkg::SR_ASPACE, srru_pkg::SR_PC,
            srru_pkg::SR_FP_STATUS, srru_pkg::SR_DISPATCH, srru_pkg::SR_SOFT_INT,
            srru_pkg::SR_TICK_CMP, srru_pkg::SR_SYS_CMP: begin
                r = srru_pkg::SRRU_OK;
            end
            srru_pkg::SR_TICK: begin
                if (!priv_mode && cycle_tick[srru_pkg::NPT_BIT]) begin
                    r = srru_pkg::SRRU_PRIV_ACTION;
                end
            end
            srru_pkg::SR_SYS_TICK: begin
                if (!priv_mode && system_tick[srru_pkg::NPT_BIT]) begin
                    r = srru_pkg::SRRU_PRIV_ACTION;
                end
            end
            srru_pkg::SR_PERF_CNT: begin
                if (!priv_mode && perf_control[srru_pkg::PCR_PRIV_BIT]) begin
                    r = srru_pkg::SRRU_PRIV_ACTION;
                end
            end
            srru_pkg::SR_PERF_CTL: begin
                if (!priv_mode) begin
                    r = srru_pkg::SRRU_PRIV_OP;
                end
            end
            srru_pkg::SR_GFX: begin
                if (!proc_state[srru_pkg::PSTATE_PEF_BIT] ||
                    !fp_status[srru_pkg::FPRS_FEF_BIT]) begin
                    r = srru_pkg::SRRU_FPU_OFF;
                end
            end
            srru_pkg::SR_BARRIER: begin
                if (f_rd != '0) begin
                    r = srru_pkg::SRRU_BAD_OPCODE;
                end else begin
                    r = f_i ? srru_pkg::SRRU_MEM_BAR : srru_pkg::SRRU_STORE_BAR;
                end
            end
            default: begin
                r = srru_pkg::SRRU_BAD_OPCODE;
            end
        endcase
        return r;
    endfunction

    // ========================================
    // Source selection for both instruction classes
    always_comb begin
        data = srru_pkg::ZERO64;
        res = srru_pkg::SRRU_OK;
        if (is_priv) begin
            res = priv_chk(f_rs1);
            case (f_rs1)
                srru_pkg::PR_TRAP_PC: data = tb_pc;
                srru_pkg::PR_TRAP_NPC: data = tb_npc;
                srru_pkg::PR_TRAP_STATE: data = tb_state;
                srru_pkg::PR_TRAP_TYPE: data = tb_type;
                srru_pkg::PR_CYCLE_TICK: data = cycle_tick;
                srru_pkg::PR_TRAP_BASE: data = trap_base;
                srru_pkg::PR_PROC_STATE: data = proc_state;
                srru_pkg::PR_TRAP_LEVEL: data = 64'(trap_level);
                srru_pkg::PR_IRQ_LEVEL: data = irq_level;
                srru_pkg::PR_WINDOW_PTR: data = window_ptr;
                srru_pkg::PR_FP_QUEUE: data = fp_queue;
                srru_pkg::PR_VERSION: data = version_reg;
                default: begin
                    if (f_rs1 >= srru_pkg::PR_WIN_FIRST && f_rs1 <= srru_pkg::PR_WIN_LAST) begin
                        data = window_ctl[3'(f_rs1 - srru_pkg::PR_WIN_FIRST)];
                    end
                end
            endcase
        end else if (is_state) begin
            res = state_chk(f_rs1);
            case (f_rs1)
                srru_pkg::SR_MULT: data = mult_reg;
                srru_pkg::SR_COND: data = cond_codes;
                srru_pkg::SR_ASPACE: data = aspace_reg;
                srru_pkg::SR_TICK: data = cycle_tick;
                srru_pkg::SR_PC: data = pc; // Full width, never masked
                srru_pkg::SR_FP_STATUS: data = fp_status;
                srru_pkg::SR_PERF_CTL: data = perf_control;
                srru_pkg::SR_PERF_CNT: data = perf_counters;
                srru_pkg::SR_DISPATCH: data = dispatch_control;
                srru_pkg::SR_GFX: data = graphics_status;
                srru_pkg::SR_SOFT_INT: data = soft_interrupt;
                srru_pkg::SR_TICK_CMP: data = tick_compare;
                srru_pkg::SR_SYS_TICK: data = system_tick;
                srru_pkg::SR_SYS_CMP: data = system_tick_compare;
                default: data = srru_pkg::ZERO64;
            endcase
        end else begin
            res = srru_pkg::SRRU_BAD_OPCODE; // Foreign opcode is refused
        end
    end

    // ========================================
    // Ready follows the drain stall; registered so the output is a flop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instr_ready <= 1'b0;
        end else if (ce) begin
            instr_ready <= !fp_busy_s;
        end
    end

    // ========================================
    // Result registers, pulse for one cycle per taken instruction
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done <= 1'b0;
            rd_data <= srru_pkg::ZERO64;
            rd_addr <= '0;
            rd_we <= 1'b0;
            bad_opcode_fault <= 1'b0;
            priv_op_fault <= 1'b0;
            priv_action_fault <= 1'b0;
            fpu_off_fault <= 1'b0;
            store_barrier <= 1'b0;
            memory_barrier <= 1'b0;
        end else if (ce) begin
            done <= instr_valid && !wait_fp;
            rd_we <= instr_valid && !wait_fp && res == srru_pkg::SRRU_OK;
            rd_addr <= f_rd;
            // Data withheld on any fault so no stale value leaks
            rd_data <= (res == srru_pkg::SRRU_OK) ? data : srru_pkg::ZERO64;
            bad_opcode_fault <= instr_valid && !wait_fp && res == srru_pkg::SRRU_BAD_OPCODE;
            priv_op_fault <= instr_valid && !wait_fp && res == srru_pkg::SRRU_PRIV_OP;
            priv_action_fault <= instr_valid && !wait_fp && res == srru_pkg::SRRU_PRIV_ACTION;
            fpu_off_fault <= instr_valid && !wait_fp && res == srru_pkg::SRRU_FPU_OFF;
            store_barrier <= instr_valid && !wait_fp && res == srru_pkg::SRRU_STORE_BAR;
            memory_barrier <= instr_valid && !wait_fp && res == srru_pkg::SRRU_MEM_BAR;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_take;
        ce && instr_valid && !wait_fp;
    endsequence

    property p_tl0_bad;
        s_take ##0 (is_priv && priv_mode && f_rs1 <= srru_pkg::PR_TRAP_TYPE && trap_level == '0)
            |=> bad_opcode_fault && !rd_we;
    endproperty
    a_tl0_bad: assert property (p_tl0_bad) else $error("trap read at level zero");

    property p_rsv_priv;
        s_take ##0 (is_priv && priv_mode && f_rs1 >= srru_pkg::PR_RSV_FIRST &&
            f_rs1 <= srru_pkg::PR_RSV_LAST) |=> bad_opcode_fault;
    endproperty
    a_rsv_priv: assert property (p_rsv_priv) else $error("reserved priv read");

    property p_user_priv;
        s_take ##0 (is_priv && !priv_mode) |=> priv_op_fault && !bad_opcode_fault;
    endproperty
    a_user_priv: assert property (p_user_priv) else $error("user priv read");

    property p_barrier;
        s_take ##0 (is_state && f_rs1 == srru_pkg::SR_BARRIER && f_rd == '0)
            |=> (store_barrier != memory_barrier) && !rd_we;
    endproperty
    a_barrier: assert property (p_barrier) else $error("barrier decode");

    property p_pc_full;
        s_take ##0 (is_state && f_rs1 == srru_pkg::SR_PC) |=> rd_data == $past(pc);
    endproperty
    a_pc_full: assert property (p_pc_full) else $error("pc not full");

    property p_fp_wait;
        ce && instr_valid && is_state && f_rs1 == srru_pkg::SR_FP_STATUS && fp_busy_s |=> !done;
    endproperty
    a_fp_wait: assert property (p_fp_wait) else $error("fp status read early");

    property p_gfx_off;
        s_take ##0 (is_state && f_rs1 == srru_pkg::SR_GFX &&
            !proc_state[srru_pkg::PSTATE_PEF_BIT]) |=> fpu_off_fault;
    endproperty
    a_gfx_off: assert property (p_gfx_off) else $error("gfx fpu off missed");

    property p_tick_npt;
        s_take ##0 (is_state && f_rs1 == srru_pkg::SR_TICK && !priv_mode &&
            cycle_tick[srru_pkg::NPT_BIT]) |=> priv_action_fault && !rd_we;
    endproperty
    a_tick_npt: assert property (p_tick_npt) else $error("tick trace fault missed");

    property p_pcr_user;
        s_take ##0 (is_state && f_rs1 == srru_pkg::SR_PERF_CTL && !priv_mode) |=> priv_op_fault;
    endproperty
    a_pcr_user: assert property (p_pcr_user) else $error("perf ctl user read");
endmodule

// ==== verilog/srru_pkg.sv ====
// Purpose: constants shared by the state register read unit
// Assumes: instruction words of 32 bits, 64-bit data path
// Notes: field positions and selector codes are named here only
package srru_pkg;
    // ========================================
    // Instruction fields
    localparam int OP_HI = 31;
    localparam int OP_LO = 30;
    localparam int RD_HI = 29;
    localparam int RD_LO = 25;
    localparam int OP3_HI = 24;
    localparam int OP3_LO = 19;
    localparam int RS1_HI = 18;
    localparam int RS1_LO = 14;
    localparam int I_BIT = 13;
    localparam logic [1:0] OP_ARITH = 2'h2;
    localparam logic [5:0] OP3_RD_STATE = 6'h28;
    localparam logic [5:0] OP3_RD_PRIV = 6'h2a;
    // ========================================
    // Privileged register selectors
    localparam logic [4:0] PR_TRAP_PC = 5'h00;
    localparam logic [4:0] PR_TRAP_NPC = 5'h01;
    localparam logic [4:0] PR_TRAP_STATE = 5'h02;
    localparam logic [4:0] PR_TRAP_TYPE = 5'h03;
    localparam logic [4:0] PR_CYCLE_TICK = 5'h04;
    localparam logic [4:0] PR_TRAP_BASE = 5'h05;
    localparam logic [4:0] PR_PROC_STATE = 5'h06;
    localparam logic [4:0] PR_TRAP_LEVEL = 5'h07;
    localparam logic [4:0] PR_IRQ_LEVEL = 5'h08;
    localparam logic [4:0] PR_WINDOW_PTR = 5'h09;
    localparam logic [4:0] PR_WIN_FIRST = 5'h0a;
    localparam logic [4:0] PR_WIN_LAST = 5'h0e;
    localparam logic [4:0] PR_FP_QUEUE = 5'h0f;
    localparam logic [4:0] PR_RSV_FIRST = 5'h10;
    localparam logic [4:0] PR_RSV_LAST = 5'h1e;
    localparam logic [4:0] PR_VERSION = 5'h1f;
    // ========================================
    // State register selectors
    localparam logic [4:0] SR_MULT = 5'h00;
    localparam logic [4:0] SR_COND = 5'h02;
    localparam logic [4:0] SR_ASPACE = 5'h03;
    localparam logic [4:0] SR_TICK = 5'h04;
    localparam logic [4:0] SR_PC = 5'h05;
    localparam logic [4:0] SR_FP_STATUS = 5'h06;
    localparam logic [4:0] SR_BARRIER = 5'h0f;
    localparam logic [4:0] SR_PERF_CTL = 5'h10;
    localparam logic [4:0] SR_PERF_CNT = 5'h11;
    localparam logic [4:0] SR_DISPATCH = 5'h12;
    localparam logic [4:0] SR_GFX = 5'h13;
    localparam logic [4:0] SR_SOFT_INT = 5'h16;
    localparam logic [4:0] SR_TICK_CMP = 5'h17;
    localparam logic [4:0] SR_SYS_TICK = 5'h18;
    localparam logic [4:0] SR_SYS_CMP = 5'h19;
    // ========================================
    // Trap levels and register bits
    localparam int MAX_TRAP_LEVEL = 5;
    localparam int TL_W = 3;
    localparam int NPT_BIT = 63;
    localparam int PCR_PRIV_BIT = 0;
    localparam int FPRS_FEF_BIT = 2;
    localparam int PSTATE_PEF_BIT = 4;
    localparam logic [63:0] ZERO64 = 64'h0;
    // ========================================
    // Outcome of one decoded instruction
    typedef enum logic [2:0] {
        SRRU_OK, SRRU_BAD_OPCODE, SRRU_PRIV_OP, SRRU_PRIV_ACTION, SRRU_FPU_OFF,
        SRRU_STORE_BAR, SRRU_MEM_BAR
    } srru_result_t;
endpackage

// ==== verilog/srru_sync3.sv ====
// Purpose: three-stage synchroniser for a pin level
// Assumes: single clock, async active-low reset
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module srru_sync3 (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Level
    input wire logic d,
    output logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ========================================
    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else if (ce) begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accept a change only once two stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= 1'b0;
        end else if (ce && (s2_reg == s3_reg)) begin
            q <= s3_reg;
        end
    end
endmodule

// ==== verilog/srru_trap_bank.sv ====
// Purpose: per-trap-level copies of the four trap registers
// Assumes: level 1..max_trap_level index entries 0..max-1
// Notes: write port is used by trap entry logic outside
`timescale 1ns/1ps
module srru_trap_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Write side
    input wire logic wr_en,
    input wire logic [srru_pkg::TL_W-1:0] wr_level,
    input wire logic [63:0] wr_pc,
    input wire logic [63:0] wr_npc,
    input wire logic [63:0] wr_state,
    input wire logic [63:0] wr_type,
    // Read side
    input wire logic [srru_pkg::TL_W-1:0] rd_level,
    output logic [63:0] rd_pc,
    output logic [63:0] rd_npc,
    output logic [63:0] rd_state,
    output logic [63:0] rd_type
);
    localparam int N = srru_pkg::MAX_TRAP_LEVEL;
    logic [63:0] pc_reg [N];
    logic [63:0] npc_reg [N];
    logic [63:0] st_reg [N];
    logic [63:0] ty_reg [N];
    logic [srru_pkg::TL_W-1:0] ridx;

    // ========================================
    // One entry per trap level
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_lvl
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    pc_reg[g] <= srru_pkg::ZERO64;
                    npc_reg[g] <= srru_pkg::ZERO64;
                    st_reg[g] <= srru_pkg::ZERO64;
                    ty_reg[g] <= srru_pkg::ZERO64;
                end else if (ce && wr_en && wr_level == srru_pkg::TL_W'(g + 1)) begin
                    pc_reg[g] <= wr_pc; // Full pc kept, never masked
                    npc_reg[g] <= wr_npc;
                    st_reg[g] <= wr_state;
                    ty_reg[g] <= wr_type;
                end
            end
        end
    endgenerate

    // Copy indexed by current level; level zero reads entry 0 harmlessly
    always_comb begin
        ridx = (rd_level == '0) ? '0 : rd_level - 1'b1;
        if (ridx >= srru_pkg::TL_W'(N)) begin
            ridx = srru_pkg::TL_W'(N - 1);
        end
        rd_pc = pc_reg[ridx];
        rd_npc = npc_reg[ridx];
        rd_state = st_reg[ridx];
        rd_type = ty_reg[ridx];
    end
endmodule

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the state register read unit
// Assumes: ce held high, one read offered every cycle
// Notes: expected results come from a bench model of the decode rules
`timescale 1ns/1ps
module tb;
    // ========================================
    // Stimulus and observation
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, iv = 1'b0, pm = 1'b0, fpb = 1'b0;
    logic twr = 1'b0, ib, pmv;
    logic [31:0] ins = '0;
    logic [2:0] tl = '0, twl = '0, t3;
    logic [63:0] tp = '0, tn = '0, ts = '0, tt = '0, dv, pdv, rdd;
    logic [63:0] rv [25];
    logic [63:0] nv [25];
    logic [63:0] wc [5];
    logic [63:0] bk [5][4];
    logic [4:0] rs1, rd, prd, rda;
    logic [5:0] op3;
    logic rdy, dn, we, f_bad, f_po, f_pa, f_fo, sbar, mbar;
    int err_total = 0, samples_checked = 0, cd, pcd, sel, k, n;
    integer seed = 32'h183b766c;
    assign wc = '{rv[5], rv[6], rv[7], rv[8], rv[9]};
    // Clock at 10 MHz
    always #50 clk = ~clk;
    srru_top dut_u (.clk(clk), .rstn(rstn), .ce(ce), .instr_valid(iv), .instr(ins),
        .pc(rv[24]), .priv_mode(pm), .instr_ready(rdy), .fp_busy(fpb), .trap_wr(twr),
        .trap_wr_level(twl), .trap_wr_pc(tp), .trap_wr_npc(tn), .trap_wr_state(ts),
        .trap_wr_type(tt), .trap_level(tl), .cycle_tick(rv[0]), .trap_base(rv[1]),
        .proc_state(rv[2]), .irq_level(rv[3]), .window_ptr(rv[4]), .window_ctl(wc),
        .fp_queue(rv[10]), .version_reg(rv[11]), .mult_reg(rv[12]), .cond_codes(rv[13]),
        .aspace_reg(rv[14]), .fp_status(rv[15]), .perf_control(rv[16]),
        .perf_counters(rv[17]), .dispatch_control(rv[18]), .graphics_status(rv[19]),
        .soft_interrupt(rv[20]), .tick_compare(rv[21]), .system_tick(rv[22]),
        .system_tick_compare(rv[23]), .done(dn), .rd_data(rdd), .rd_addr(rda), .rd_we(we),
        .bad_opcode_fault(f_bad), .priv_op_fault(f_po), .priv_action_fault(f_pa),
        .fpu_off_fault(f_fo), .store_barrier(sbar), .memory_barrier(mbar));
    // ========================================
    // Comparison helpers
    task ck(string nm, logic [63:0] e, logic [63:0] s);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Outcome code 0 ok, 1..6 one flag in port order
    task chk(int c, logic [63:0] d, logic [4:0] a);
        logic [5:0] fl;
        fl = (c == 0) ? 6'h00 : 6'h20 >> (c - 1);
        ck("done", 64'h1, 64'(dn));
        ck("flags", 64'(fl), 64'({f_bad, f_po, f_pa, f_fo, sbar, mbar}));
        ck("rd_we", 64'(c == 0), 64'(we));
        // Faulted or barrier results must carry zero data
        ck("rd_data", d, rdd);
        ck("rd_addr", 64'(a), 64'(rda));
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ========================================
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        $display("watchdog expired");
        final_report();
    end
    // Main sequence: reset, trap copies, random reads, fp drain
    initial begin
        for (k = 0; k < 25; k++) rv[k] = '0;
        for (k = 0; k < 20; k++) bk[k / 4][k % 4] = {$random(seed), $random(seed)};
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 5; k++) begin
            @(posedge clk);
            twr <= 1'b1;
            twl <= 3'(k + 1);
            tp <= bk[k][0];
            tn <= bk[k][1];
            ts <= bk[k][2];
            tt <= bk[k][3];
        end
        @(posedge clk);
        twr <= 1'b0;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            for (k = 0; k < 25; k++) nv[k] = {$random(seed), $random(seed)};
            {rs1, rd, ib, pmv} = 12'($random(seed));
            // Steer draws onto barriers, system tick and perf counters, rare otherwise
            if (n % 8 == 1) {rs1, rd} = 10'h1e0;
            if (n % 8 == 3) rs1 = (n % 16 == 3) ? 5'h18 : 5'h11;
            t3 = 3'({$random(seed)} % 6);
            sel = {$random(seed)} % 3;
            // Privilege behaviour of these selectors is left open, so run them privileged
            if (sel == 1 && (rs1 == 18 || rs1 == 22 || rs1 == 23 || rs1 == 25)) pmv = 1'b1;
            op3 = (sel == 0) ? 6'h2a : (sel == 1) ? 6'h28 : 6'h2e;
            cd = 0;
            dv = '0;
            if (sel == 2) cd = 1;
            else if (sel == 0) begin
                if (!pmv) cd = 2;
                else if (rs1 >= 16 && rs1 <= 30) cd = 1;
                else if (rs1 <= 3 && t3 == 0) cd = 1;
                else if (rs1 <= 3) dv = bk[t3 - 1][rs1];
                else if (rs1 == 7) dv = 64'(t3);
                else dv = nv[rs1 == 31 ? 11 : rs1 == 15 ? 10 : rs1 <= 6 ? rs1 - 4 : rs1 - 5];
            end else begin
                if (rs1 == 1 || (rs1 >= 7 && rs1 <= 14) || rs1 == 20 || rs1 == 21 || rs1 >= 26)
                    cd = 1;
                else if (rs1 == 15) cd = (rd != 0) ? 1 : ib ? 6 : 5;
                else if (!pmv && ((rs1 == 4 && nv[0][63]) || (rs1 == 24 && nv[22][63])
                    || (rs1 == 17 && nv[16][0]))) cd = 3;
                else if (!pmv && rs1 == 16) cd = 2;
                else if (rs1 == 19 && !(nv[2][4] && nv[15][2])) cd = 4;
                else dv = nv[rs1 == 4 ? 0 : rs1 == 6 ? 15 : rs1 == 5 ? 24 : rs1 == 0 ? 12 :
                    rs1 <= 3 ? rs1 + 11 : rs1 <= 19 ? rs1 : rs1 - 2];
            end
            for (k = 0; k < 25; k++) rv[k] <= nv[k];
            ins <= {2'h2, rd, op3, rs1, ib, 13'h0};
            tl <= t3;
            pm <= pmv;
            iv <= 1'b1;
            @(negedge clk);
            if (n > 0) chk(pcd, pdv, prd);
            pcd = cd;
            pdv = dv;
            prd = rd;
        end
        @(posedge clk);
        iv <= 1'b0;
        fpb <= 1'b1;
        @(negedge clk);
        chk(pcd, pdv, prd);
        repeat (5) @(posedge clk);
        ins <= {2'h2, 5'h03, 6'h28, 5'h06, 14'h0};
        iv <= 1'b1;
        repeat (3) begin
            @(negedge clk);
            ck("fp stall", 64'h0, 64'({dn, rdy}));
        end
        @(posedge clk);
        fpb <= 1'b0;
        n = 0;
        while (dn !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        ck("fp drain done", 64'h1, 64'(dn));
        ck("ready after drain", 64'h1, 64'(rdy));
        ck("fp status data", rv[15], rdd);
        @(posedge clk);
        iv <= 1'b0;
        final_report();
    end
endmodule
